// ### src/tbs_tx_sideband.sv
// What this block does
// - Pin is bus sideband when bus enabled
// - Bus channels 2,3 share framer 6,7
// - Narrow parity covers eight data bits
// - Wide parity adds payload and C1/J1
// - Control byte picks parity polarity, coverage
// - Alarm declares AIS-P for that STS-1
// - Loop/async modes drive pulse pin out
// - Pulse one bit, one bit before frame
// - External mode aligns frames to pulses
// - Bypassed generator leaves pin idle
// - Add bus latched on bus clock fall
`timescale 1ns/1ns
`default_nettype none

module tbs_tx_sideband
  import tbs_pkg::*;
#(
  parameter int FRAME_BITS = tbs_pkg::DS3_FRAME_BITS
)
(
  input  wire logic                                      i_sys_clk,
  input  wire logic                                      i_rst,
  input  wire logic [15:0]                               i_reg_addr,
  input  wire logic [7:0]                                i_reg_wdata,
  input  wire logic                                      i_reg_wr,
  input  wire logic                                      i_reg_rd,
  output logic      [7:0]                                o_reg_rdata,
  input  wire tbs_pkg::tbs_add_bus_type [tbs_pkg::NUM_CH-1:0] i_add_bus,
  input  wire logic [tbs_pkg::NUM_CH-1:0]                i_trib_bit_clk,
  input  wire logic [tbs_pkg::NUM_CH-1:0]                i_shared_pin,
  output logic      [tbs_pkg::NUM_CH-1:0]                o_shared_pin,
  output logic      [tbs_pkg::NUM_CH-1:0]                o_shared_pin_oe,
  output logic      [tbs_pkg::NUM_CH-1:0]                o_parity_err,
  output logic      [tbs_pkg::NUM_CH-1:0][2:0]           o_ais_p,
  output logic      [tbs_pkg::NUM_CH-1:0]                o_frame_start
);

  import tbs_pkg::*;

  // ****************************************************************
  // State and per-channel strobes
  // ****************************************************************
  tbs_state_type     state_reg;
  tbs_state_type     state_next;
  logic [NUM_CH-1:0] sel;
  logic [NUM_CH-1:0] byte_edge;
  logic [NUM_CH-1:0] bit_edge;
  logic [NUM_CH-1:0] par_bad;
  logic [NUM_CH-1:0] fr_act;
  logic [NUM_CH-1:0] fp_drive;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Pins are slow against the system clock, so every pin is
  // synchronised and edges are found on the synchronised copies.
  always_comb
  begin
    tbs_ch_type       cur;
    tbs_ch_type       nxt;
    tbs_fmode_type    mode;
    logic [CNT_W-1:0] idx;
    logic [1:0]       slot_now;
    logic             par;
    cur        = '0;
    nxt        = '0;
    mode       = FM_LOOP;
    idx        = '0;
    slot_now   = '0;
    par        = 1'b0;
    state_next = state_reg;
    sel        = '0;
    byte_edge  = '0;
    bit_edge   = '0;
    par_bad    = '0;
    fr_act     = '0;
    fp_drive   = '0;
    state_next.rdata = 8'h00;

    // Control byte decode; index 0 is bus ch 2, index 1 bus ch 3
    if (i_reg_addr == CTRL_ADDR_CH2)
    begin
      sel[0] = 1'b1;
    end
    else if (i_reg_addr == CTRL_ADDR_CH3)
    begin
      sel[1] = 1'b1;
    end

    for (int c = 0; c < NUM_CH; c++)
    begin
      cur  = state_reg.ch[c];
      nxt  = cur;
      mode = tbs_fmode_type'(cur.ctrl[FR_MODE_LSB +: 2]);

      // Two-flop synchronisers for every pin
      nxt.bus_s1    = i_add_bus[c];
      nxt.bus_s2    = cur.bus_s1;
      nxt.pin_s1    = i_shared_pin[c];
      nxt.pin_s2    = cur.pin_s1;
      nxt.bclk_s1   = i_trib_bit_clk[c];
      nxt.bclk_s2   = cur.bclk_s1;
      nxt.bus_clk_d = cur.bus_s2.clk;
      nxt.bit_clk_d = cur.bclk_s2;

      // Bus byte taken on the falling bus clock, bus role only
      byte_edge[c] = cur.bus_clk_d & ~cur.bus_s2.clk
                     & cur.ctrl[BUS_EN_BIT];
      bit_edge[c]  = ~cur.bit_clk_d & cur.bclk_s2;

      // Framer owns the pin only with the bus off and not bypassed
      fr_act[c]   = ~cur.ctrl[BUS_EN_BIT] & cur.ctrl[FR_EN_BIT]
                    & (mode != FM_BYPASS);
      fp_drive[c] = fr_act[c] & (mode != FM_EXT_PULSE);

      // Parity: zero means the pin matches the chosen polarity
      par = (^cur.bus_s2.data) ^ cur.pin_s2
            ^ cur.ctrl[PAR_ODD_BIT];
      par = par ^ (cur.ctrl[PAR_WIDE_BIT]
            & (cur.bus_s2.pl ^ cur.bus_s2.c1j1));
      par_bad[c] = byte_edge[c] & par;

      // Software write; a set in the same cycle wins over the clear
      if (i_reg_wr && sel[c])
      begin
        nxt.ctrl = i_reg_wdata & CTRL_WMASK;
        if (i_reg_wdata[PERR_BIT])
        begin
          nxt.perr = 1'b0;
        end
      end
      if (par_bad[c])
      begin
        nxt.perr = 1'b1;
      end

      // STS-1 slot tracking; a C1 byte restarts the interleave
      if (!cur.ctrl[BUS_EN_BIT])
      begin
        nxt.ais  = '0;
        nxt.slot = '0;
      end
      else if (byte_edge[c])
      begin
        if (cur.bus_s2.c1j1 && !cur.bus_s2.pl)
        begin
          slot_now = 2'd0;
        end
        else
        begin
          slot_now = cur.slot;
        end
        nxt.ais[slot_now] = cur.bus_s2.alarm;
        if (slot_now == 2'(STS1_SLOTS - 1))
        begin
          nxt.slot = 2'd0;
        end
        else
        begin
          nxt.slot = slot_now + 2'd1;
        end
      end

      // Frame generator, counting tributary bit periods
      nxt.fstart = 1'b0;
      if (!fr_act[c])
      begin
        nxt.cnt    = '0;
        nxt.fp_out = 1'b0;
      end
      else if (bit_edge[c])
      begin
        if (mode == FM_EXT_PULSE && cur.pin_s2)
        begin
          idx = '0;
        end
        else if (cur.cnt == CNT_W'(FRAME_BITS - 1))
        begin
          idx = '0;
        end
        else
        begin
          idx = cur.cnt + 1'b1;
        end
        nxt.cnt    = idx;
        nxt.fstart = (idx == '0);
        // High through the last bit, i.e. one bit before frame start
        nxt.fp_out = (mode != FM_EXT_PULSE)
                     && (idx == CNT_W'(FRAME_BITS - 1));
      end

      // Read returns AIS summary, sticky error and control bits
      if (i_reg_rd && sel[c])
      begin
        state_next.rdata = {|cur.ais, cur.perr, cur.ctrl[5:0]};
      end

      state_next.ch[c] = nxt;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_reg_rdata = state_reg.rdata;

  // ****************************************************************
  // Per-channel outputs and checks
  // ****************************************************************
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    localparam logic [15:0] ADDR = (g == 0) ? CTRL_ADDR_CH2 : CTRL_ADDR_CH3;
    tbs_ch_type    cs;
    tbs_fmode_type md;
    logic          clr_hit;

    assign cs                 = state_reg.ch[g];
    assign md                 = tbs_fmode_type'(cs.ctrl[FR_MODE_LSB +: 2]);
    assign clr_hit            = i_reg_wr && (i_reg_addr == ADDR)
                                && i_reg_wdata[PERR_BIT];
    // Pin drives only while the generator owns it as an output
    assign o_shared_pin[g]    = cs.fp_out;
    assign o_shared_pin_oe[g] = fp_drive[g];
    assign o_parity_err[g]    = cs.perr;
    assign o_ais_p[g]         = cs.ais;
    assign o_frame_start[g]   = cs.fstart;

    a_bus_owns_pin: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      cs.ctrl[BUS_EN_BIT] |-> !o_shared_pin_oe[g])
      else $error("pin driven while bus enabled");

    a_bypass_idle: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (md == FM_BYPASS || !cs.ctrl[FR_EN_BIT])
      |-> !o_shared_pin_oe[g] ##1 !o_frame_start[g])
      else $error("bypassed generator still active");

    a_fp_bit_wide: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      $changed(o_shared_pin[g]) && $past(fr_act[g])
      |-> $past(bit_edge[g]))
      else $error("frame pulse changed between bit edges");

    a_fp_precedes: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      o_frame_start[g] && $past(fp_drive[g]) |-> $past(o_shared_pin[g]))
      else $error("frame start without prior pulse");

    a_ext_align: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      fr_act[g] && md == FM_EXT_PULSE && bit_edge[g] && cs.pin_s2
      |=> o_frame_start[g] && cs.cnt == '0)
      else $error("frame not aligned to input pulse");

    a_par_narrow: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      byte_edge[g] && !cs.ctrl[PAR_WIDE_BIT]
      && ((^cs.bus_s2.data) ^ cs.pin_s2 ^ cs.ctrl[PAR_ODD_BIT])
      |=> o_parity_err[g])
      else $error("narrow parity error missed");

    a_par_wide: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      byte_edge[g] && cs.ctrl[PAR_WIDE_BIT]
      && ((^cs.bus_s2.data) ^ cs.bus_s2.pl ^ cs.bus_s2.c1j1
          ^ cs.pin_s2 ^ cs.ctrl[PAR_ODD_BIT])
      |=> o_parity_err[g])
      else $error("wide parity error missed");

    a_perr_hold: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      o_parity_err[g] && !clr_hit |=> o_parity_err[g])
      else $error("parity flag dropped without clear");

    a_ais_declare: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      byte_edge[g] && cs.bus_s2.alarm |=> o_ais_p[g] != 3'b000)
      else $error("alarm byte did not declare AIS-P");

    a_ctrl_write: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      i_reg_wr && i_reg_addr == ADDR
      |=> cs.ctrl == ($past(i_reg_wdata) & CTRL_WMASK))
      else $error("control byte not written");

    c_ext_align: cover property (
      @(posedge i_sys_clk) disable iff (i_rst)
      md == FM_EXT_PULSE && o_frame_start[g]);

    c_fp_pulse: cover property (
      @(posedge i_sys_clk) disable iff (i_rst)
      o_shared_pin_oe[g] && $fell(o_shared_pin[g]));

    c_parity_err: cover property (
      @(posedge i_sys_clk) disable iff (i_rst)
      $rose(o_parity_err[g]));

    c_ais: cover property (
      @(posedge i_sys_clk) disable iff (i_rst)
      $rose(|o_ais_p[g]));
  end

endmodule : tbs_tx_sideband

`default_nettype wire

// ### src/tbs_pkg.sv
package tbs_pkg;

  // ****************************************************************
  // Channel map and register map
  // ****************************************************************
  // Index 0 is bus channel 2 sharing with framer channel 6,
  // index 1 is bus channel 3 sharing with framer channel 7
  localparam int          NUM_CH        = 2;
  localparam int          STS1_SLOTS    = 3;
  localparam logic [15:0] CTRL_ADDR_CH3 = 16'h0138;
  localparam logic [15:0] CTRL_ADDR_CH2 = 16'h0139;
  localparam logic [7:0]  CTRL_WMASK    = 8'h3F;

  // Control byte fields
  localparam int BUS_EN_BIT   = 0;
  localparam int PAR_ODD_BIT  = 1;
  localparam int PAR_WIDE_BIT = 2;
  localparam int FR_EN_BIT    = 3;
  localparam int FR_MODE_LSB  = 4;
  localparam int PERR_BIT     = 6;
  localparam int AIS_BIT      = 7;

  // ****************************************************************
  // Frame generator timing
  // ****************************************************************
  localparam int DS3_FRAME_BITS = 4760;
  localparam int CNT_W          = 13;

  typedef enum logic [1:0] {
    FM_LOOP,
    FM_ASYNC,
    FM_EXT_PULSE,
    FM_BYPASS
  } tbs_fmode_type;

  // Add-bus pins of one channel
  typedef struct packed {
    logic       clk;
    logic [7:0] data;
    logic       pl;
    logic       c1j1;
    logic       alarm;
  } tbs_add_bus_type;

  // State of one channel
  typedef struct packed {
    logic [7:0]      ctrl;
    logic            perr;
    logic [2:0]      ais;
    logic [1:0]      slot;
    tbs_add_bus_type bus_s1;
    tbs_add_bus_type bus_s2;
    logic            bus_clk_d;
    logic            pin_s1;
    logic            pin_s2;
    logic            bclk_s1;
    logic            bclk_s2;
    logic            bit_clk_d;
    logic [CNT_W-1:0] cnt;
    logic            fp_out;
    logic            fstart;
  } tbs_ch_type;

  typedef struct packed {
    tbs_ch_type [NUM_CH-1:0] ch;
    logic [7:0]              rdata;
  } tbs_state_type;

  localparam tbs_state_type STATE_RESET = '0;

endpackage : tbs_pkg

// ### bench/tbs_src_model.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Far side of one channel: add bus source and tributary bit clock
// ****************************************************************
module tbs_src_model
  import tbs_pkg::*;
(
  input  wire logic      i_sys_clk,
  output tbs_add_bus_type o_bus,
  output logic           o_bit_clk,
  output logic           o_pin
);
  // Idle lines at time zero
  initial
  begin
    o_bus     = '0;
    o_bit_clk = 1'b0;
    o_pin     = 1'b0;
  end

  // One byte, pins held four cycles either side of the falling bus clock
  task automatic send(input logic [7:0] d, input logic pl, input logic cj, input logic al,
                      input logic odd, input logic wide, input logic bad);
    logic p;
    p = ^d ^ odd ^ (wide & (pl ^ cj)) ^ bad;
    @(posedge i_sys_clk);
    o_bus <= '{clk: 1'b1, data: d, pl: pl, c1j1: cj, alarm: al};
    o_pin <= p;
    repeat (4) @(posedge i_sys_clk);
    o_bus.clk <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    o_bus.data <= ~d; // Held time over: show junk, not the old byte
    o_pin      <= ~p;
  endtask : send

  // Bit periods of eight cycles; pin high for the whole bit numbered mark
  task automatic bits(input int n, input int mark);
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_sys_clk);
      o_bit_clk <= 1'b1;
      o_pin     <= (i == mark);
      repeat (4) @(posedge i_sys_clk);
      o_bit_clk <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
    end
  endtask : bits
endmodule : tbs_src_model

`default_nettype wire

// ### bench/tbs_tx_sideband_test.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Self-checking bench
// ****************************************************************
module tbs_tx_sideband_test;
  import tbs_pkg::*;
  logic                 clk, rst, wr, rd, rd_d;
  logic [15:0]          addr;
  logic [7:0]           wdata, rdata, cv;
  wire tbs_add_bus_type [1:0] bus;
  wire logic [1:0]      bclk, mpin, pin_in;
  logic [1:0]           pin_out, oe, perr, fstart, pin_d;
  logic [1:0][2:0]      ais;
  logic [7:0]           starts [2];
  logic [7:0]           hi [2];
  logic [7:0]           exp_q [$];
  logic [7:0]           fm [4] = '{8'h08, 8'h18, 8'h38, 8'h09};
  logic [7:0]           fs [4] = '{8'h02, 8'h02, 8'h00, 8'h00};
  int                   fail_count = 0;
  int                   tests_run = 0;

  // Shared pin level: the device wins while it drives
  assign pin_in = (oe & pin_out) | (~oe & mpin);

  tbs_tx_sideband #(.FRAME_BITS(8)) tbs_tx_sideband_i (
    .i_sys_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_add_bus(bus),
    .i_trib_bit_clk(bclk), .i_shared_pin(pin_in), .o_shared_pin(pin_out),
    .o_shared_pin_oe(oe), .o_parity_err(perr), .o_ais_p(ais), .o_frame_start(fstart));
  tbs_src_model src0_i (.i_sys_clk(clk), .o_bus(bus[0]), .o_bit_clk(bclk[0]), .o_pin(mpin[0]));
  tbs_src_model src1_i (.i_sys_clk(clk), .o_bus(bus[1]), .o_bit_clk(bclk[1]), .o_pin(mpin[1]));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  function automatic logic [15:0] ad(input int c);
    return (c == 1) ? CTRL_ADDR_CH3 : CTRL_ADDR_CH2;
  endfunction : ad

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // The expected byte is noted when the read is issued
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  // Read answers against the oldest note; frame pulse statistics
  always @(posedge clk)
  begin
    rd_d  <= rd;
    pin_d <= pin_out;
    if (rd_d && exp_q.size() > 0)
      check(rdata, exp_q.pop_front());
    for (int c = 0; c < 2; c++)
    begin
      // A driven frame start must follow a cycle with the pulse high
      if (fstart[c] === 1'b1 && oe[c] === 1'b1)
        check({7'h00, pin_d[c]}, 8'h01);
      starts[c] += 8'(fstart[c] === 1'b1);
      hi[c]     += 8'(pin_out[c] === 1'b1);
    end
  end

  // Hang guard, far beyond the under one thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  initial
  begin
    {rst, wr, rd, addr, wdata} = {1'b1, 2'b00, 16'h0000, 8'h00};
    void'($urandom(27515));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped place, stored bits only
    rd_reg(CTRL_ADDR_CH2, 8'h00);
    rd_reg(CTRL_ADDR_CH3, 8'h00);
    wr_reg(16'h013A, 8'h3F);
    rd_reg(16'h013A, 8'h00);
    wr_reg(CTRL_ADDR_CH3, 8'hFF);
    rd_reg(CTRL_ADDR_CH3, 8'h3F);
    $display("register test done");
    // Every polarity and coverage, good and bad byte, both channels
    for (int c = 0; c < 2; c++)
      for (int m = 0; m < 4; m++)
        for (int b = 0; b < 2; b++)
        begin
          cv = {5'b0_0000, m[1], m[0], 1'b1};
          wr_reg(ad(c), cv | 8'h40);
          if (c == 0)
            src0_i.send(8'($urandom), 1'b1, 1'b0, 1'b0, m[0], m[1], b[0]);
          else
            src1_i.send(8'($urandom), 1'b1, 1'b0, 1'b0, m[0], m[1], b[0]);
          repeat (2) @(posedge clk);
          check({7'h00, perr[c]}, 8'(b));
          rd_reg(ad(c), cv | 8'(b << 6));
        end
    $display("parity test done");
    // Alarm on the second STS-1 of three, first byte marks slot 0
    wr_reg(CTRL_ADDR_CH2, 8'h41);
    for (int s = 0; s < 3; s++)
      src0_i.send(8'($urandom), s != 0, s == 0, s == 1, 1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    check({5'h00, ais[0]}, 8'h02);
    rd_reg(CTRL_ADDR_CH2, 8'h81);
    wr_reg(CTRL_ADDR_CH2, 8'h00);
    repeat (2) @(posedge clk);
    check({5'h00, ais[0]}, 8'h00);
    $display("alarm test done");
    // Loop, async, bypass, bus enabled on one pin
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(CTRL_ADDR_CH3, fm[k]);
      @(posedge clk);
      starts[1] = 8'h00;
      hi[1]     = 8'h00;
      check({7'h00, oe[1]}, 8'(fs[k] != 0));
      src1_i.bits(16, -1);
      repeat (4) @(posedge clk);
      check(starts[1], fs[k]);
      check(hi[1], 8'(fs[k] * 8));
    end
    $display("frame output test done");
    // External pulse at bit 3 moves the frame boundary there
    wr_reg(CTRL_ADDR_CH2, 8'h28);
    @(posedge clk);
    starts[0] = 8'h00;
    check({7'h00, oe[0]}, 8'h00);
    src0_i.bits(12, 3);
    repeat (4) @(posedge clk);
    check(starts[0], 8'h02);
    $display("frame input test done");
    give_verdict();
  end
endmodule : tbs_tx_sideband_test

`default_nettype wire
